// File: pkg/ocs_pkg.sv
package ocs_pkg;

  // Clock and time base.
  localparam int unsigned CLK_NS      = 50;
  localparam int unsigned MS_NS       = 1000000;
  localparam int unsigned MS_CLKS_DEF = MS_NS / CLK_NS;
  localparam int unsigned PCYC_MS     = 5;
  localparam int unsigned BLK_LEAD_MS = 5;

  // Pick-up release ratio in percent of the threshold.
  localparam int unsigned REL_PCT  = 97;
  localparam int unsigned PCT_FULL = 100;

  // Operation log depth, and the register address width.
  localparam int unsigned LOG_DEPTH = 12;
  localparam int unsigned AW        = 8;

  // Register byte offsets.
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_THR    = 8'h04;
  localparam logic [7:0] A_OPDLY  = 8'h08;
  localparam logic [7:0] A_RSTDLY = 8'h0C;
  localparam logic [7:0] A_INRLIM = 8'h10;
  localparam logic [7:0] A_EVMASK = 8'h14;
  localparam logic [7:0] A_STATUS = 8'h18;
  localparam logic [7:0] A_IRQST  = 8'h1C;
  localparam logic [7:0] A_IRQCLR = 8'h20;
  localparam logic [7:0] A_IRQEN  = 8'h24;
  localparam logic [7:0] A_LOGSEL = 8'h28;
  localparam logic [7:0] A_LOGW0  = 8'h2C;
  localparam logic [7:0] A_LOGW1  = 8'h30;
  localparam logic [7:0] A_LOGW2  = 8'h34;
  localparam logic [7:0] A_LOGW3  = 8'h38;
  localparam logic [7:0] A_TIME   = 8'h3C;

  // Field positions.
  localparam int unsigned CTRL_MODE   = 0;
  localparam int unsigned CTRL_INR    = 1;
  localparam int unsigned CTRL_SG     = 2;
  localparam int unsigned EVM_OFF_LSB = 16;

  // Values after reset.
  localparam logic [15:0] RST_THR     = 16'h0078;
  localparam logic [15:0] RST_OPDLY   = 16'h0064;
  localparam logic [15:0] RST_RSTDLY  = 16'h0032;
  localparam logic [15:0] RST_INRLIM  = 16'h0001;
  localparam logic [8:0]  RST_ONMASK  = 9'h1FF;
  localparam logic [8:0]  RST_OFFMASK = 9'h1FF;

  // Record event kinds.
  localparam logic [1:0] EV_START = 2'h1;
  localparam logic [1:0] EV_TRIP  = 2'h2;
  localparam logic [1:0] EV_BLK   = 2'h3;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_START = 5'b00010,
    ST_TRIP  = 5'b00100,
    ST_BLKD  = 5'b01000,
    ST_REL   = 5'b10000
  } ocs_state_t;

  typedef struct packed {
    logic [31:0] tstamp;
    logic [1:0]  ev;
    logic [2:0]  ftype;
    logic [15:0] pre20;
    logic [15:0] fault;
    logic [15:0] pre200;
    logic [15:0] rem;
    logic [2:0]  sg;
  } ocs_rec_t;

endpackage : ocs_pkg

// File: pkg/ocs_log_if.sv
`timescale 1ns/10ps
interface ocs_log_if;
  import ocs_pkg::*;
  logic           we;
  logic [3:0]     waddr;
  ocs_rec_t       wdata;
  logic [3:0]     raddr;
  ocs_rec_t       rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : ocs_log_if

// File: verilog/ocs_log_mem.sv
`timescale 1ns/10ps
module ocs_log_mem (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Log port.
  ocs_log_if.mem   lg
);
  import ocs_pkg::*;

  typedef struct packed {
    ocs_rec_t [LOG_DEPTH-1:0] arr;
    ocs_rec_t                 rd;
  } ocs_mem_st_t;

  ocs_mem_st_t q;
  ocs_mem_st_t s;

  // Write port, and a registered read so the bus sees a stable word.
  always_comb begin
    s = q;
    if (lg.we && (32'(lg.waddr) < LOG_DEPTH)) begin
      s.arr[lg.waddr] = lg.wdata;
    end
    s.rd = (32'(lg.raddr) < LOG_DEPTH) ? q.arr[lg.raddr] : '0;
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= s;
    end
  end

  assign lg.rdata = q.rd;

endmodule : ocs_log_mem

// File: verilog/ocs_stage.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Sample block input once per program cycle.
// - Pick-up without block asserts start, starts timing.
// - Pick-up under block asserts blocked, no timing.
// - Block during start clears start, runs release.
// - Optional second-harmonic inrush block, default off.
// - Inrush limit in 0.01 percent steps.
// - Blocking gives notification and time-stamped event.
// - Fixed or inverse-time operate delay modes.
// - Events on every status edge, masked.
// - Three instances, each own event group.
// - Events carry time stamp and process data.
// - Circular log of last twelve records.
// - Log written only on activating edges.
// - Record holds time, event, currents, group.
// - Pick-up when any phase exceeds threshold.
// - Pick-up releases below fixed 97 percent.
module ocs_stage #(
  parameter int unsigned STAGE_ID = 1,
  parameter int unsigned MS_CLKS  = ocs_pkg::MS_CLKS_DEF
) (
  // Clock and reset.
  input  logic                    pclk,
  input  logic                    presetn,
  // APB slave.
  input  logic                    psel,
  input  logic                    penable,
  input  logic                    pwrite,
  input  logic [ocs_pkg::AW-1:0]  paddr,
  input  logic [31:0]             pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Measurement data, same clock.
  input  logic [15:0]             meas_a,
  input  logic [15:0]             meas_b,
  input  logic [15:0]             meas_c,
  input  logic [15:0]             harm2_ratio,
  input  logic [15:0]             pre20_cur,
  input  logic [15:0]             pre200_cur,
  // Block input from the blocking matrix pin.
  input  logic                    block_pin,
  // Stage outputs.
  output logic                    start,
  output logic                    trip,
  output logic                    blocked,
  output logic [2:0]              phase_start,
  output logic [2:0]              phase_trip,
  output logic                    hmi_note,
  // Event stream.
  output logic                    evt_valid,
  output logic [6:0]              evt_code,
  output logic [31:0]             evt_time,
  output logic [18:0]             evt_data,
  // Interrupt.
  output logic                    irq
);
  import ocs_pkg::*;

  localparam int unsigned CW  = $clog2(MS_CLKS);
  localparam logic [1:0]  SID = 2'(STAGE_ID);

  if (STAGE_ID < 1 || STAGE_ID > 3 || MS_CLKS < 2) begin : g_bad_param
    $error("ocs_stage: STAGE_ID must be 1 to 3 and MS_CLKS at least 2");
  end

  typedef struct packed {
    logic [1:0]    bsync;
    logic          blk_smp;
    logic [CW-1:0] clk_cnt;
    logic [2:0]    ms_in_cyc;
    logic          tick;
    logic [31:0]   now_ms;
    logic          mode;
    logic          inr_en;
    logic [2:0]    sg;
    logic [15:0]   thr;
    logic [15:0]   opdly;
    logic [15:0]   rstdly;
    logic [15:0]   inr_lim;
    logic [8:0]    on_mask;
    logic [8:0]    off_mask;
    logic [2:0]    irq_st;
    logic [2:0]    irq_en;
    logic          irq;
    logic [3:0]    log_sel;
    ocs_state_t    fsm;
    logic [2:0]    pk;
    logic [15:0]   fcur;
    logic [31:0]   acc;
    logic [15:0]   rel;
    logic [8:0]    stat;
    logic [8:0]    pend_on;
    logic [8:0]    pend_off;
    logic          hmi_note;
    logic          evt_valid;
    logic [6:0]    evt_code;
    logic [31:0]   evt_time;
    logic [18:0]   evt_data;
    logic          we;
    logic [3:0]    waddr;
    logic [3:0]    wptr;
    logic [3:0]    cnt;
    ocs_rec_t      wrec;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
  } ocs_st_t;

  localparam ocs_st_t Q_RST = '{
    fsm: ST_IDLE, thr: RST_THR, opdly: RST_OPDLY, rstdly: RST_RSTDLY,
    inr_lim: RST_INRLIM, on_mask: RST_ONMASK, off_mask: RST_OFFMASK,
    default: '0};

  ocs_st_t          q;
  ocs_st_t          s;
  ocs_log_if        lg ();
  logic [2:0][15:0] meas;
  logic             blk_now;
  logic             inrush;
  logic             blkc;
  logic [2:0]       pk_n;
  logic [15:0]      imax;
  logic [15:0]      excess;
  logic [31:0]      step;
  logic [31:0]      target;
  logic [31:0]      acc_n;
  logic [16:0]      rel_n;
  logic [31:0]      rem32;
  logic [15:0]      rem;
  logic             startish;
  logic [8:0]       stat_n;
  logic [2:0]       rise;
  logic [2:0]       clr;
  logic             setup;
  logic             wr;
  logic [3:0]       idx;

  // Pick-up sets above threshold and holds until under the release ratio.
  function automatic logic ocs_pk(input logic held, input logic [15:0] m, input logic [15:0] t);
    logic [31:0] lhs;
    logic [31:0] rhs;
    lhs = {16'h0000, m} * PCT_FULL;
    rhs = {16'h0000, t} * REL_PCT;
    return held ? (lhs >= rhs) : (m > t);
  endfunction : ocs_pk

  // Lowest set bit index of a pending event vector.
  function automatic logic [3:0] ocs_first(input logic [8:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 8; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : ocs_first

  // Word-aligned offsets inside the register window.
  function automatic logic ocs_mapped(input logic [AW-1:0] a);
    return (a[1:0] == 2'b00) && (a <= A_TIME);
  endfunction : ocs_mapped

  assign meas = {meas_c, meas_b, meas_a};

  // Next-state logic for the whole stage.
  always_comb begin
    s           = q;
    s.tick      = 1'b0;
    s.we        = 1'b0;
    s.hmi_note  = 1'b0;
    s.evt_valid = 1'b0;
    s.pready    = 1'b0;
    s.pslverr   = 1'b0;
    s.prdata    = 32'h0000_0000;
    s.bsync     = {q.bsync[0], block_pin};
    blk_now     = q.bsync[1];
    inrush      = q.inr_en && (harm2_ratio > q.inr_lim);
    blkc        = blk_now || inrush;
    for (int i = 0; i < 3; i++) begin
      pk_n[i] = ocs_pk(q.pk[i], meas[i], q.thr);
    end
    imax   = (meas[0] > meas[1]) ? meas[0] : meas[1];
    imax   = (imax > meas[2]) ? imax : meas[2];
    excess = (imax > q.thr) ? (imax - q.thr) : 16'h0000;
    // Inverse time integrates the overcurrent so that delay shrinks as it grows.
    step   = q.mode ? (32'(excess) * PCYC_MS) : PCYC_MS;
    target = q.mode ? (32'(q.opdly) * 32'(q.thr)) : 32'(q.opdly);
    acc_n  = q.acc + step;
    rel_n  = {1'b0, q.rel} + 17'(PCYC_MS);

    // Millisecond time base and program cycle tick.
    if (q.clk_cnt == CW'(MS_CLKS - 1)) begin
      s.clk_cnt = '0;
      s.now_ms  = q.now_ms + 32'h0000_0001;
      if (q.ms_in_cyc == 3'(PCYC_MS - 1)) begin
        s.ms_in_cyc = 3'h0;
        s.tick      = 1'b1;
      end else begin
        s.ms_in_cyc = q.ms_in_cyc + 3'h1;
      end
    end else begin
      s.clk_cnt = q.clk_cnt + CW'(1);
    end

    // Once per program cycle; the block level is frozen for the whole cycle.
    // A block seen on the tick that ends the delay still wins over the trip; one seen after that tick is too late.
    if (q.tick) begin
      s.blk_smp = blk_now;
      s.pk      = pk_n;
      s.fcur    = imax;
      unique case (q.fsm)
        ST_IDLE: begin
          if (|pk_n) begin
            s.fsm = blkc ? ST_BLKD : ST_START;
          end
        end
        ST_START: begin
          if (!(|pk_n) || blkc) begin
            s.fsm = ST_REL;
            s.rel = 16'h0000;
          end else begin
            s.acc = acc_n;
            if (acc_n >= target) begin
              s.fsm = ST_TRIP;
            end
          end
        end
        ST_TRIP: begin
          if (!(|pk_n)) begin
            s.fsm = ST_IDLE;
            s.acc = 32'h0000_0000;
          end
        end
        ST_BLKD: begin
          if (!(|pk_n)) begin
            s.fsm = ST_IDLE;
          end
        end
        ST_REL: begin
          if ((|pk_n) && !blkc) begin
            s.fsm = ST_START;
          end else if (rel_n >= {1'b0, q.rstdly}) begin
            s.acc = 32'h0000_0000;
            s.fsm = (|pk_n) ? ST_BLKD : ST_IDLE;
          end else begin
            s.rel = rel_n[15:0];
          end
        end
        default: begin
          s.fsm = ST_IDLE;
          s.acc = 32'h0000_0000;
        end
      endcase
    end

    // Status vector; edges are taken against the last program cycle.
    startish = (s.fsm == ST_START) || (s.fsm == ST_TRIP);
    stat_n   = {s.pk & {3{s.fsm == ST_TRIP}}, s.pk & {3{startish}},
                s.fsm == ST_BLKD, s.fsm == ST_TRIP, startish};
    rise     = stat_n[2:0] & ~q.stat[2:0];
    s.stat   = stat_n;
    s.pend_on  = q.pend_on | (stat_n & ~q.stat & q.on_mask);
    s.pend_off = q.pend_off | (~stat_n & q.stat & q.off_mask);
    s.hmi_note = rise[2];

    // Remaining time is exact in fixed mode; inverse mode reports all ones.
    rem32 = (target > s.acc) ? (target - s.acc) : 32'h0000_0000;
    rem   = (q.mode || (|rem32[31:16])) ? 16'hFFFF : rem32[15:0];

    // One record per activating edge, into a ring of twelve.
    if (|rise) begin
      s.we    = 1'b1;
      s.waddr = q.wptr;
      s.wptr  = (q.wptr == 4'(LOG_DEPTH - 1)) ? 4'h0 : q.wptr + 4'h1;
      s.cnt   = (q.cnt == 4'(LOG_DEPTH)) ? q.cnt : q.cnt + 4'h1;
      s.wrec  = '{tstamp: q.now_ms,
                  ev:     rise[1] ? EV_TRIP : (rise[2] ? EV_BLK : EV_START),
                  ftype:  pk_n,
                  pre20:  pre20_cur,
                  fault:  imax,
                  pre200: pre200_cur,
                  rem:    rem,
                  sg:     q.sg};
    end

    // Drain one event per clock, activating edges first.
    if (|s.pend_on) begin
      idx         = ocs_first(s.pend_on);
      s.evt_valid = 1'b1;
      s.evt_code  = {SID, idx, 1'b1};
      s.pend_on[idx] = 1'b0;
    end else if (|s.pend_off) begin
      idx         = ocs_first(s.pend_off);
      s.evt_valid = 1'b1;
      s.evt_code  = {SID, idx, 1'b0};
      s.pend_off[idx] = 1'b0;
    end else begin
      idx = 4'h0;
    end
    if (s.evt_valid) begin
      s.evt_time = q.now_ms;
      s.evt_data = {s.pk, s.fcur};
    end

    // APB: decode in setup, answer with pready in the access cycle.
    setup     = psel && !penable;
    wr        = psel && penable && q.pready && pwrite && !q.pslverr;
    s.pready  = setup;
    s.pslverr = setup && !ocs_mapped(paddr);
    clr       = (wr && paddr == A_IRQCLR) ? pwdata[2:0] : 3'h0;
    // A new edge in the clearing cycle survives.
    s.irq_st  = (q.irq_st & ~clr) | rise;
    if (setup && !pwrite) begin
      unique case (paddr)
        A_CTRL:   s.prdata = {27'h0000_000, q.sg, q.inr_en, q.mode};
        A_THR:    s.prdata = {16'h0000, q.thr};
        A_OPDLY:  s.prdata = {16'h0000, q.opdly};
        A_RSTDLY: s.prdata = {16'h0000, q.rstdly};
        A_INRLIM: s.prdata = {16'h0000, q.inr_lim};
        A_EVMASK: s.prdata = {7'h00, q.off_mask, 7'h00, q.on_mask};
        A_STATUS: s.prdata = {10'h000, q.blk_smp, q.cnt, 3'h0, q.fsm, q.stat};
        A_IRQST:  s.prdata = {29'h0000_0000, q.irq_st};
        A_IRQEN:  s.prdata = {29'h0000_0000, q.irq_en};
        A_LOGSEL: s.prdata = {28'h0000_000, q.log_sel};
        A_LOGW0:  s.prdata = lg.rdata.tstamp;
        A_LOGW1:  s.prdata = {lg.rdata.pre20, lg.rdata.fault};
        A_LOGW2:  s.prdata = {lg.rdata.pre200, lg.rdata.rem};
        A_LOGW3:  s.prdata = {24'h0000_00, lg.rdata.ev, lg.rdata.ftype, lg.rdata.sg};
        A_TIME:   s.prdata = q.now_ms;
        default:  s.prdata = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      unique case (paddr)
        A_CTRL: begin
          s.mode   = pwdata[CTRL_MODE];
          s.inr_en = pwdata[CTRL_INR];
          s.sg     = pwdata[CTRL_SG +: 3];
        end
        A_THR:    s.thr     = pwdata[15:0];
        A_OPDLY:  s.opdly   = pwdata[15:0];
        A_RSTDLY: s.rstdly  = pwdata[15:0];
        A_INRLIM: s.inr_lim = pwdata[15:0];
        A_EVMASK: begin
          s.on_mask  = pwdata[8:0];
          s.off_mask = pwdata[EVM_OFF_LSB +: 9];
        end
        A_IRQEN:  s.irq_en  = pwdata[2:0];
        A_LOGSEL: s.log_sel = pwdata[3:0];
        A_TIME:   s.now_ms  = pwdata;
        default:  s.log_sel = q.log_sel;
      endcase
    end
    s.irq = |(s.irq_st & s.irq_en);
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= Q_RST;
    end else begin
      q <= s;
    end
  end

  ocs_log_mem u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .lg      (lg.mem)
  );

  // Log port and top outputs, all straight from flops.
  assign lg.we       = q.we;
  assign lg.waddr    = q.waddr;
  assign lg.wdata    = q.wrec;
  assign lg.raddr    = q.log_sel;
  assign prdata      = q.prdata;
  assign pready      = q.pready;
  assign pslverr     = q.pslverr;
  assign start       = q.stat[0];
  assign trip        = q.stat[1];
  assign blocked     = q.stat[2];
  assign phase_start = q.stat[5:3];
  assign phase_trip  = q.stat[8:6];
  assign hmi_note    = q.hmi_note;
  assign evt_valid   = q.evt_valid;
  assign evt_code    = q.evt_code;
  assign evt_time    = q.evt_time;
  assign evt_data    = q.evt_data;
  assign irq         = q.irq;

  // Checks of the stage behaviour.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_block_sample: assert property (!q.tick |=> $stable(q.blk_smp))
    else $error("block sample moved outside a program cycle tick");
  chk_start_entry: assert property (q.tick && q.fsm == ST_IDLE && (|pk_n) && !blkc |=> start && !blocked)
    else $error("pick-up without block did not give start");
  chk_block_entry: assert property (q.tick && q.fsm == ST_IDLE && (|pk_n) && blkc |=> blocked && !start)
    else $error("pick-up under block did not give blocked");
  chk_start_release: assert property (q.tick && q.fsm == ST_START && blkc |=> q.fsm == ST_REL && !start)
    else $error("block during start did not enter release");
  chk_inrush_off: assert property (q.tick && q.fsm == ST_IDLE && (|pk_n) && !q.inr_en && !blk_now |=> start)
    else $error("disabled inrush block stopped a start");
  chk_inrush_limit: assert property (q.tick && q.fsm == ST_IDLE && (|pk_n) &&
                                     q.inr_en && harm2_ratio > q.inr_lim |=> blocked && !start)
    else $error("ratio above limit did not block");
  chk_block_note: assert property ($rose(blocked) |-> hmi_note)
    else $error("blocking without notification");
  chk_fixed_delay: assert property ($rose(trip) && !q.mode |-> q.acc >= 32'(q.opdly))
    else $error("fixed mode trip before delay");
  chk_event_edge: assert property ($rose(start) && q.on_mask[0] |-> ##[0:18] (evt_valid && evt_code[4:0] == 5'h01))
    else $error("start edge produced no event");
  chk_event_group: assert property (evt_valid |-> evt_code[6:5] == SID)
    else $error("event carries wrong group");
  chk_log_ring: assert property (32'(q.wptr) < LOG_DEPTH && 32'(q.cnt) <= LOG_DEPTH)
    else $error("log pointer or count out of range");
  chk_log_on_rise: assert property (q.we |-> (|(q.stat[2:0] & ~$past(q.stat[2:0]))))
    else $error("log written without activating edge");
  chk_pickup_set: assert property (q.tick && meas_a > q.thr |=> q.pk[0])
    else $error("phase above threshold did not pick up");
  chk_pickup_hold: assert property (q.tick && q.pk[0] && ({16'h0000, meas_a} * PCT_FULL >= {16'h0000, q.thr} * REL_PCT) |=> q.pk[0])
    else $error("pick-up released above release ratio");

  cov_trip: cover property ($rose(trip));
  cov_release_restart: cover property (q.fsm == ST_REL ##[1:1000] q.fsm == ST_START);
  cov_log_wrap: cover property (32'(q.cnt) == LOG_DEPTH && q.we);

endmodule : ocs_stage

// File: bench/ocs_blk_src.sv
`timescale 1ns/10ps
// Stand-in for the blocking matrix that feeds the block pin.
module ocs_blk_src (
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Request from the bench and the pin it drives.
  input  wire logic req,
  output logic      block_pin
);
  // Registered so the pin only moves after a clock edge, as matrix logic does.
  // The bench raises it whole ticks ahead of any operate delay, so it always lands in time.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_pin <= 1'b0;
    end else begin
      block_pin <= req;
    end
  end
endmodule : ocs_blk_src

// File: bench/testbench.sv
`timescale 1ns/10ps
module testbench;
  import ocs_pkg::*;
  // Clocks per program tick with the short millisecond count used here.
  localparam int MSC  = 4;
  localparam int TICK = PCYC_MS * MSC;
  localparam logic [7:0] RA[6] = '{A_CTRL, A_THR, A_OPDLY, A_RSTDLY, A_INRLIM, A_EVMASK};
  localparam logic [31:0] RV[6] = '{32'h0000_0000, 32'h0000_0078, 32'h0000_0064, 32'h0000_0032,
                                    32'h0000_0001, 32'h01FF_01FF};
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, blk_req = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, evt_time, rnd = 32'h0001_2627, rd;
  logic [15:0] meas_a = '0, meas_b = '0, meas_c = '0, harm2_ratio = '0, pre20_cur = '0, pre200_cur = '0;
  logic        pready, pslverr, block_pin, start, trip, blocked, hmi_note, evt_valid, irq, er;
  logic [2:0]  phase_start, phase_trip;
  logic [6:0]  evt_code;
  logic [18:0] evt_data;
  logic [127:0] seen = '0;
  logic        hmi_seen = 0;
  logic [3:0]  st;
  logic [15:0] e20, v1;
  logic [31:0] t_got = '0, t_exp = '0;
  logic [18:0] d_got = '0;
  logic        clr_seen = 0;
  int          ncyc = 0;
  int          fail_count = 0, checks = 0, p = 0;

  ocs_stage #(.STAGE_ID(1), .MS_CLKS(MSC)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .meas_a, .meas_b, .meas_c, .harm2_ratio, .pre20_cur, .pre200_cur,
    .block_pin, .start, .trip, .blocked, .phase_start, .phase_trip, .hmi_note, .evt_valid, .evt_code,
    .evt_time, .evt_data, .irq);
  ocs_blk_src PM (.pclk, .presetn, .req(blk_req), .block_pin);

  // Clock at 20 MHz.
  always #25 pclk = ~pclk;
  assign st = {irq, blocked, trip, start};

  // Events and notes last one cycle, so remember every one that passes.
  // The first start event also keeps its stamp, against the bench's own millisecond count.
  always @(posedge pclk) begin
    if (presetn) ncyc <= ncyc + 1;
    if (clr_seen) seen <= '0;
    else if (evt_valid === 1'b1) seen[evt_code] <= 1'b1;
    if (evt_valid === 1'b1 && evt_code == evc(0, 1'b1) && !seen[evt_code]) begin
      t_got <= evt_time;
      t_exp <= 32'((ncyc - 1) / MSC);
      d_got <= evt_data;
    end
    if (hmi_note === 1'b1) hmi_seen <= 1'b1;
  end

  // Program ticks to an inverse-time trip at a steady current with reset settings.
  function automatic int itks(input int i);
    int stp;
    stp = int'(PCYC_MS) * (i - int'(RST_THR));
    return (int'(RST_OPDLY) * int'(RST_THR) + stp - 1) / stp;
  endfunction : itks

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Event code expected from this instance for a status bit and edge.
  function automatic logic [6:0] evc(input int idx, input logic on);
    return {2'h1, idx[3:0], on};
  endfunction : evc

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic summarize();
    $display("fail_count=%0d checks=%0d", fail_count, checks);
    if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 1, 32'(n < 16));
    if (n >= 16) summarize();
  endtask : apb

  // Bounded wait for one status output to reach a level.
  task automatic wait_st(input int b, input logic v, input int lim, input string nm);
    int n;
    n = 0;
    while (st[b] !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk(nm, 32'(v), 32'(st[b]));
    if (st[b] !== v) summarize();
  endtask : wait_st

  task automatic ticks(input int k);
    repeat (k * TICK) @(posedge pclk);
  endtask : ticks

  // Drive a magnitude on the chosen phase with fresh random history currents.
  task automatic pick(input logic [15:0] v);
    rnd = lfsr(rnd);
    pre20_cur <= rnd[15:0];
    pre200_cur <= rnd[31:16];
    meas_a <= (p == 0) ? v : 16'h0000;
    meas_b <= (p == 1) ? v : 16'h0000;
    meas_c <= (p == 2) ? v : 16'h0000;
  endtask : pick

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (RA[i]) begin
      apb(1'b0, RA[i], '0);
      chk("reset value", RV[i], rd);
      chk("no error", 0, 32'(er));
    end
    apb(1'b0, 8'h40, '0);
    chk("unmapped error", 1, 32'(er));
    apb(1'b1, A_IRQEN, 32'h0000_0002);
    // Random phase, current between one step and 256 steps over the threshold.
    rnd = lfsr(rnd);
    p = int'(rnd % 3);
    v1 = 16'h0079 + 16'(rnd[7:0]);
    pick(v1);
    e20 = rnd[15:0];
    wait_st(0, 1'b1, 3 * TICK, "start");
    chk("phase start", 32'(3'h1 << p), 32'(phase_start));
    chk("irq masked", 0, 32'(irq));
    apb(1'b0, A_IRQST, '0);
    chk("irq status start", 1, 32'(rd[0]));
    // Hysteresis band edges: 117 holds, 116 releases.
    pick(16'h0075);
    ticks(3);
    chk("start held", 1, 32'(start));
    pick(16'h0074);
    wait_st(0, 1'b0, 3 * TICK, "start release");
    pick(16'h00C8 + 16'(rnd[7:0]));
    wait_st(1, 1'b1, 30 * TICK, "trip");
    chk("phase trip", 32'(3'h1 << p), 32'(phase_trip));
    chk("irq raised", 1, 32'(irq));
    apb(1'b1, A_IRQCLR, 32'h0000_0007);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 0, 32'(irq));
    chk("ev start on", 1, 32'(seen[evc(0, 1'b1)]));
    chk("ev start off", 1, 32'(seen[evc(0, 1'b0)]));
    chk("ev phase start", 1, 32'(seen[evc(3 + p, 1'b1)]));
    chk("ev trip on", 1, 32'(seen[evc(1, 1'b1)]));
    chk("ev phase trip", 1, 32'(seen[evc(6 + p, 1'b1)]));
    chk("ev stamp", t_exp, t_got);
    chk("ev data", 32'({3'(1 << p), v1}), 32'(d_got));
    // First record holds the first start and its history current.
    apb(1'b1, A_LOGSEL, '0);
    repeat (2) @(posedge pclk);
    apb(1'b0, A_LOGW3, '0);
    chk("log kind", 32'(EV_START), 32'(rd[7:6]));
    apb(1'b0, A_LOGW1, '0);
    chk("log pre20", 32'(e20), 32'(rd[31:16]));
    pick(16'h0000);
    wait_st(1, 1'b0, 40 * TICK, "trip clear");
    wait_st(0, 1'b0, 40 * TICK, "start clear");
    // Block first, then pick-up.
    blk_req <= 1'b1;
    ticks(1);
    pick(16'h00C8);
    wait_st(2, 1'b1, 3 * TICK, "blocked");
    chk("start under block", 0, 32'(start));
    ticks(25);
    chk("no trip under block", 0, 32'(trip));
    chk("display note", 1, 32'(hmi_seen));
    chk("ev block on", 1, 32'(seen[evc(2, 1'b1)]));
    blk_req <= 1'b0;
    pick(16'h0000);
    wait_st(2, 1'b0, 3 * TICK, "blocked clear");
    // Block arriving while started.
    pick(16'h00C8);
    wait_st(0, 1'b1, 3 * TICK, "restart");
    blk_req <= 1'b1;
    wait_st(0, 1'b0, 3 * TICK, "start cleared by block");
    ticks(25);
    chk("no trip after block", 0, 32'(trip));
    blk_req <= 1'b0;
    pick(16'h0000);
    wait_st(2, 1'b0, 3 * TICK, "blocked clear");
    // Internal harmonic block over its limit.
    apb(1'b1, A_INRLIM, 32'h0000_0064);
    apb(1'b1, A_CTRL, 32'h0000_0002);
    harm2_ratio <= 16'h00C8;
    pick(16'h00C8);
    wait_st(2, 1'b1, 3 * TICK, "harmonic block");
    chk("start under harmonic", 0, 32'(start));
    // Inverse time with trip-on and all off events masked: a high current trips early.
    harm2_ratio <= '0;
    pick(16'h0000);
    wait_st(2, 1'b0, 3 * TICK, "harmonic clear");
    apb(1'b1, A_EVMASK, 32'h0000_01FD);
    apb(1'b1, A_CTRL, 32'h0000_0001);
    clr_seen <= 1'b1;
    @(posedge pclk);
    clr_seen <= 1'b0;
    pick(16'h0258);
    wait_st(0, 1'b1, 3 * TICK, "inverse start");
    ticks(itks(16'h0258) - 1);
    chk("inverse early", 0, 32'(trip));
    wait_st(1, 1'b1, 2 * TICK, "inverse trip");
    pick(16'h0000);
    wait_st(1, 1'b0, 3 * TICK, "inverse clear");
    repeat (4) @(posedge pclk);
    chk("mask start on", 1, 32'(seen[evc(0, 1'b1)]));
    chk("mask trip on", 0, 32'(seen[evc(1, 1'b1)]));
    chk("mask phase trip", 1, 32'(seen[evc(6 + p, 1'b1)]));
    chk("mask trip off", 0, 32'(seen[evc(1, 1'b0)]));
    summarize();
  end
endmodule : testbench
